// ==== pkg/rtccs_regs.vh ====
// Register offsets, bit positions, reset values and timing counts of the RTC control block
`ifndef RTCCS_REGS_VH
`define RTCCS_REGS_VH

// Byte locations
`define RTCCS_OFF_RATE_CTRL   8'h0a
`define RTCCS_OFF_TIME_CTRL   8'h0b
`define RTCCS_OFF_INT_FLAGS   8'h0c
`define RTCCS_OFF_PWR_STATUS  8'h0d
`define RTCCS_OFF_INT_STATUS  8'h0e
`define RTCCS_OFF_INT_MASK    8'h0f

// time_control bits
`define RTCCS_TC_HALT     7
`define RTCCS_TC_PIE      6
`define RTCCS_TC_AIE      5
`define RTCCS_TC_UIE      4
`define RTCCS_TC_RSVD     3
`define RTCCS_TC_BIN      2
`define RTCCS_TC_H24      1
`define RTCCS_TC_DST      0

// interrupt_flags bits
`define RTCCS_IF_IRQ      7
`define RTCCS_IF_PF       6
`define RTCCS_IF_AF       5
`define RTCCS_IF_UF       4

// power_status bit
`define RTCCS_PS_VALID    7

// Reset values
`define RTCCS_TC_RESET    8'h02
`define RTCCS_RATE_RESET  8'h26
`define RTCCS_MASK_RESET  8'h00

// Timing: update-in-progress window in us, 100 MHz clock
`define RTCCS_UIP_US      2444
`define RTCCS_CLK_MHZ     100
`define RTCCS_UIP_CYC     (`RTCCS_UIP_US * `RTCCS_CLK_MHZ)
// Shortest periodic interval 122.070 us, expressed in ns
`define RTCCS_TICK_NS     122070
`define RTCCS_CLK_NS      10
`define RTCCS_TICK_CYC    (`RTCCS_TICK_NS / `RTCCS_CLK_NS)
// One second in cycles
`define RTCCS_SEC_CYC     100000000

`endif

// ==== src/rtccs_periodic.v ====
// Periodic interrupt divider selected by the rate field
`timescale 1ns/100ps
`include "rtccs_regs.vh"
module rtccs_periodic #(
    parameter TICK_CYC = `RTCCS_TICK_CYC
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       nrst,
    // Control
    input  wire [3:0] rate,
    // Event
    output reg        pulse_r
);
    reg  [31:0] pre_r;
    reg  [12:0] div_r;
    reg  [12:0] div_prev_r;
    wire        tick;
    reg  [3:0]  sel;
    wire        hit;

    assign tick = (pre_r == TICK_CYC - 1);

    // Bit k of the tick counter rises every 2^(k+1) ticks, so codes 4 to 15 use bit n-4; code 3 fires on every tick
    // Codes 1 and 2 fold onto the 3.9 ms and 7.8 ms taps
    always @* begin
        case (rate)
            4'h0:    sel = 4'h0;
            4'h1:    sel = 4'h4;
            4'h2:    sel = 4'h5;
            4'h3:    sel = 4'h0;
            default: sel = rate - 4'h4;
        endcase
    end

    assign hit = (rate != 4'h0) && tick &&
                 (rate == 4'h3 ? 1'b1 : (div_r[sel] & ~div_prev_r[sel]));

    always @(posedge mclk) begin
        if (!nrst) begin
            pre_r      <= 32'h0;
            div_r      <= 13'h0;
            div_prev_r <= 13'h0;
            pulse_r    <= 1'b0;
        end else begin
            pre_r   <= tick ? 32'h0 : pre_r + 32'h1;
            pulse_r <= hit;
            if (tick) begin
                div_prev_r <= div_r;
                div_r      <= div_r + 13'h1;
            end
        end
    end
endmodule

// ==== src/rtccs_update.v ====
// One-second update sequencer with update-in-progress window
`timescale 1ns/100ps
`include "rtccs_regs.vh"
module rtccs_update #(
    parameter SEC_CYC = `RTCCS_SEC_CYC,
    parameter UIP_CYC = `RTCCS_UIP_CYC
) (
    // Clock and reset
    input  wire mclk,
    input  wire nrst,
    // Control
    input  wire halt,
    // Status and events
    output reg  uip_r,
    output reg  upd_r
);
    reg [31:0] cnt_r;

    always @(posedge mclk) begin
        if (!nrst) begin
            cnt_r <= 32'h0;
            uip_r <= 1'b0;
            upd_r <= 1'b0;
        end else if (halt) begin
            cnt_r <= 32'h0;
            uip_r <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == SEC_CYC - 1) ? 32'h0 : cnt_r + 32'h1;
            upd_r <= (cnt_r == SEC_CYC - 1);
            uip_r <= (cnt_r >= SEC_CYC - 1 - UIP_CYC) && (cnt_r != SEC_CYC - 1);
        end
    end
endmodule

// ==== src/rtccs_top.v ====
// Control and status registers of the real-time clock
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "rtccs_regs.vh"
module rtccs_top #(
    parameter SEC_CYC = `RTCCS_SEC_CYC,
    parameter UIP_CYC = `RTCCS_UIP_CYC
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       nrst,
    // Register port
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata_r,
    // Time keeping side
    input  wire       alarm_match,
    input  wire       pwr_good,
    input  wire       dst_fwd_day,
    input  wire       dst_back_day,
    output reg        halt_r,
    output reg        bin_mode_r,
    output reg        h24_mode_r,
    output reg        dst_fwd_r,
    output reg        dst_back_r,
    // Interrupts
    output reg        rtc_irq_r,
    output reg        irq_r
);
    reg  [7:0] tc_r;
    reg  [3:0] rate_r;
    reg  [2:0] flags_r;
    reg  [2:0] sts_r;
    reg  [2:0] mask_r;
    reg  [2:0] alarm_s_r;
    reg  [1:0] pwr_s_r;
    reg  [1:0] fwd_s_r;
    reg  [1:0] back_s_r;
    reg        fwd_d_r;
    reg        back_d_r;
    reg        pwr_lost_r;
    wire       alarm_ev;
    wire       per_ev;
    wire       upd_ev;
    wire       uip;
    wire       rd_flags;
    wire [2:0] ev;
    wire [2:0] flags_nxt;
    wire [2:0] sts_nxt;
    wire       irq_nxt;

    rtccs_periodic u_per (
        .mclk    (mclk),
        .nrst    (nrst),
        .rate    (rate_r),
        .pulse_r (per_ev)
    );

    rtccs_update #(
        .SEC_CYC (SEC_CYC),
        .UIP_CYC (UIP_CYC)
    ) u_upd (
        .mclk  (mclk),
        .nrst  (nrst),
        .halt  (tc_r[`RTCCS_TC_HALT]),
        .uip_r (uip),
        .upd_r (upd_ev)
    );

    // Alarm comes from the pin side; rising edge after synchroniser
    assign alarm_ev = alarm_s_r[1] & ~alarm_s_r[2];

    // Flag order {periodic, alarm, update}; flags set regardless of enables
    assign ev       = {per_ev, alarm_ev, upd_ev};
    assign rd_flags = rd && (addr == `RTCCS_OFF_INT_FLAGS);
    // Set wins over the read-clear so an event in the read cycle survives
    assign flags_nxt = (rd_flags ? 3'h0 : flags_r) | ev;
    assign irq_nxt   = |(flags_nxt & {tc_r[`RTCCS_TC_PIE], tc_r[`RTCCS_TC_AIE],
                                     tc_r[`RTCCS_TC_UIE]});
    assign sts_nxt   = (sts_r & ~((wr && addr == `RTCCS_OFF_INT_STATUS) ?
                                  wdata[6:4] : 3'h0)) | ev;

    always @(posedge mclk) begin
        if (!nrst) begin
            tc_r       <= `RTCCS_TC_RESET;
            rate_r     <= 4'h6;
            flags_r    <= 3'h0;
            sts_r      <= 3'h0;
            mask_r     <= 3'h0;
            alarm_s_r  <= 3'h0;
            // Idle level of a good supply, so leaving reset invents no power loss
            pwr_s_r    <= 2'h3;
            fwd_s_r    <= 2'h0;
            back_s_r   <= 2'h0;
            fwd_d_r    <= 1'b0;
            back_d_r   <= 1'b0;
            pwr_lost_r <= 1'b0;
            rdata_r    <= 8'h00;
            halt_r     <= 1'b0;
            bin_mode_r <= 1'b0;
            h24_mode_r <= 1'b1;
            dst_fwd_r  <= 1'b0;
            dst_back_r <= 1'b0;
            rtc_irq_r  <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            alarm_s_r <= {alarm_s_r[1:0], alarm_match};
            pwr_s_r   <= {pwr_s_r[0], pwr_good};
            fwd_s_r   <= {fwd_s_r[0], dst_fwd_day};
            back_s_r  <= {back_s_r[0], dst_back_day};
            fwd_d_r   <= fwd_s_r[1];
            back_d_r  <= back_s_r[1];
            // Sticky until the power bit is read, so a brownout is never missed
            if (!pwr_s_r[1])
                pwr_lost_r <= 1'b1;
            else if (rd && addr == `RTCCS_OFF_PWR_STATUS)
                pwr_lost_r <= 1'b0;
            if (wr) begin
                case (addr)
                    `RTCCS_OFF_RATE_CTRL: rate_r <= wdata[3:0];
                    `RTCCS_OFF_TIME_CTRL: tc_r   <= wdata & 8'hf7;
                    `RTCCS_OFF_INT_MASK:  mask_r <= wdata[6:4];
                    default: ;
                endcase
            end
            flags_r    <= flags_nxt;
            sts_r      <= sts_nxt;
            rtc_irq_r  <= irq_nxt;
            irq_r      <= |(sts_nxt & mask_r);
            halt_r     <= tc_r[`RTCCS_TC_HALT];
            bin_mode_r <= tc_r[`RTCCS_TC_BIN];
            h24_mode_r <= tc_r[`RTCCS_TC_H24];
            // Day strobes from the calendar qualify the hour-change pulses
            dst_fwd_r  <= tc_r[`RTCCS_TC_DST] & fwd_s_r[1] & ~fwd_d_r;
            dst_back_r <= tc_r[`RTCCS_TC_DST] & back_s_r[1] & ~back_d_r;
            rdata_r    <= 8'h00;
            if (rd) begin
                case (addr)
                    `RTCCS_OFF_RATE_CTRL:  rdata_r <= {uip, 3'h2, rate_r};
                    `RTCCS_OFF_TIME_CTRL:  rdata_r <= tc_r;
                    `RTCCS_OFF_INT_FLAGS:  rdata_r <= {rtc_irq_r, flags_r, 4'h0};
                    `RTCCS_OFF_PWR_STATUS: rdata_r <= {~pwr_lost_r, 7'h00};
                    `RTCCS_OFF_INT_STATUS: rdata_r <= {1'b0, sts_r, 4'h0};
                    `RTCCS_OFF_INT_MASK:   rdata_r <= {1'b0, mask_r, 4'h0};
                    default:               rdata_r <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ==== bench/rtccs_checker.sv ====
// Port assertions for the RTC control block
`timescale 1ns/100ps
module rtccs_checker #(
    parameter SEC_CYC = 2000,
    parameter UIP_CYC = 50
) (
    // Clock, reset and register port
    input wire       mclk,
    input wire       nrst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata_r,
    // Time keeping side and interrupts
    input wire       alarm_match,
    input wire       pwr_good,
    input wire       dst_fwd_r,
    input wire       dst_back_r,
    input wire       halt_r,
    input wire       bin_mode_r,
    input wire       h24_mode_r,
    input wire       rtc_irq_r
);
    // Shadow of the control byte, so enables can be judged from the ports
    reg [7:0] ctrl_r;
    always @(posedge mclk) begin
        if (!nrst)
            ctrl_r <= 8'h02;
        else if (wr && addr == 8'h0b)
            ctrl_r <= wdata;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_halt_write:
    assert property (wr && addr == 8'h0b |=> ##1 halt_r == $past(wdata[7], 2))
        else $error("halt bad");
    a_fmt_write:
    assert property (wr && addr == 8'h0b |=> ##1 {bin_mode_r, h24_mode_r} == $past(wdata[2:1], 2))
        else $error("mode bad");
    a_rsvd_zero:
    assert property (rd && addr == 8'h0b |=> !rdata_r[3]) else $error("bit 3 set");
    a_flag_irq:
    assert property (rd && addr == 8'h0c && rtc_irq_r |=> rdata_r[7]) else $error("bit 7 low");
    a_irq_enable:
    assert property ((ctrl_r[6:4] == 3'h0) [*2] |-> !rtc_irq_r) else $error("irq unenabled");
    a_alarm_irq:
    assert property ($rose(alarm_match) && ctrl_r[5] && !rd |-> ##[1:8] rtc_irq_r)
        else $error("no alarm irq");
    a_dst_gate:
    assert property (dst_fwd_r || dst_back_r |-> ctrl_r[0] || $past(ctrl_r[0]))
        else $error("shift unenabled");
    a_dst_pulse:
    assert property (dst_fwd_r |=> !dst_fwd_r) else $error("shift too long");
    a_pwr_loss:
    assert property ((!pwr_good) [*4] ##0 (rd && addr == 8'h0d) |=> !rdata_r[7])
        else $error("power bit high");
    c_update: cover property (rd && addr == 8'h0c ##1 rdata_r[4]);
    c_periodic: cover property (rtc_irq_r && ctrl_r[6]);
    c_back: cover property (dst_back_r);
endmodule
bind rtccs_top rtccs_checker #(.SEC_CYC(SEC_CYC), .UIP_CYC(UIP_CYC)) u_chk (.mclk, .nrst,
    .addr, .wdata, .wr, .rd, .rdata_r, .alarm_match, .pwr_good, .dst_fwd_r, .dst_back_r,
    .halt_r, .bin_mode_r, .h24_mode_r, .rtc_irq_r);

// ==== bench/tb_rtccs_top.sv ====
// Directed testbench for the RTC control and status registers
`timescale 1ns/100ps
module tb_rtccs_top;
    reg        mclk = 1'b0;
    reg        nrst = 1'b0;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg  [2:0] ev = 3'h0;
    reg        pwr_good = 1'b1;
    reg  [3:0] n_fwd = 4'h0;
    reg  [3:0] n_back = 4'h0;
    wire [7:0] rdata_r;
    wire       halt_r, bin_mode_r, h24_mode_r, dst_fwd_r, dst_back_r, rtc_irq_r, irq_r;
    integer    n_fail = 0;
    integer    total_checks = 0;
    integer    n_wait = 0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        n_fwd <= n_fwd + {3'h0, dst_fwd_r};
        n_back <= n_back + {3'h0, dst_back_r};
    end
    // Short second so the update interrupt arrives within a few thousand cycles
    rtccs_top #(.SEC_CYC(2000), .UIP_CYC(50)) DUT (.mclk(mclk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .alarm_match(ev[0]),
        .pwr_good(pwr_good), .dst_fwd_day(ev[1]), .dst_back_day(ev[2]), .halt_r(halt_r),
        .bin_mode_r(bin_mode_r), .h24_mode_r(h24_mode_r), .dst_fwd_r(dst_fwd_r),
        .dst_back_r(dst_back_r), .rtc_irq_r(rtc_irq_r), .irq_r(irq_r));
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input string nm);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wt(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge mclk);
            wr <= 1'b0;
        end
    endtask
    task rq(input [7:0] a);
        begin
            @(posedge mclk);
            addr <= a;
            rd <= 1'b1;
            @(posedge mclk);
            rd <= 1'b0;
            #1;
        end
    endtask
    task rc(input [7:0] a, input [7:0] exp, input string nm);
        begin
            rq(a);
            chk(rdata_r, exp, nm);
        end
    endtask
    // Event lines are slow levels, held long enough for the synchronisers
    task pulse(input [2:0] m);
        begin
            @(posedge mclk);
            ev <= m;
            repeat (4) @(posedge mclk);
            ev <= 3'h0;
            repeat (6) @(posedge mclk);
            #1;
        end
    endtask
    task wirq(input integer n);
        integer i;
        begin
            for (i = 0; i < n && rtc_irq_r !== 1'b1; i = i + 1) begin
                @(posedge mclk);
                #1;
            end
            n_wait = i;
        end
    endtask
    initial begin
        repeat (90000) @(posedge mclk);
        n_fail = n_fail + 1;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        wt(8'h0a, 8'h20);
        rc(8'h0b, 8'h02, "ctrl");
        chk({5'h00, halt_r, bin_mode_r, h24_mode_r}, 8'h01, "modes");
        rc(8'h30, 8'h00, "unmapped");
        rc(8'h0a, 8'h20, "rate");
        rc(8'h0d, 8'h80, "power");
        wt(8'h0c, 8'hff);
        rc(8'h0c, 8'h00, "flags");
        wt(8'h0b, 8'hff);
        rc(8'h0b, 8'hf7, "ctrl");
        chk({5'h00, halt_r, bin_mode_r, h24_mode_r}, 8'h07, "modes");
        wt(8'h0b, 8'h10);
        // Mode outputs follow the control byte one cycle after it lands
        @(posedge mclk);
        #1;
        chk({5'h00, halt_r, bin_mode_r, h24_mode_r}, 8'h00, "modes");
        $display("test control done");
        // Counter restarts at the halt release; the window opens 50 cycles before the update
        repeat (1960) @(posedge mclk);
        rc(8'h0a, 8'ha0, "rate");
        wirq(2100);
        rc(8'h0c, 8'h90, "flags");
        rc(8'h0c, 8'h00, "flags");
        chk({7'h00, rtc_irq_r}, 8'h00, "irq");
        wt(8'h0b, 8'h90);
        repeat (2500) @(posedge mclk);
        rc(8'h0c, 8'h00, "flags");
        $display("test update done");
        wt(8'h0e, 8'h70);
        pulse(3'h1);
        chk({7'h00, rtc_irq_r}, 8'h00, "irq");
        rc(8'h0c, 8'h20, "flags");
        wt(8'h0b, 8'ha0);
        pulse(3'h1);
        chk({6'h00, rtc_irq_r, irq_r}, 8'h02, "irqs");
        rc(8'h0c, 8'ha0, "flags");
        wt(8'h0f, 8'h20);
        rc(8'h0f, 8'h20, "mask");
        chk({7'h00, irq_r}, 8'h01, "irq");
        wt(8'h0e, 8'h20);
        rc(8'h0e, 8'h00, "status");
        chk({7'h00, irq_r}, 8'h00, "irq");
        $display("test alarm done");
        wt(8'h0a, 8'h23);
        wt(8'h0b, 8'hc0);
        wirq(13000);
        rc(8'h0c, 8'hc0, "flags");
        // Code 4 is two base ticks of 12207 cycles; the gap starts after the clearing read
        wt(8'h0a, 8'h24);
        wirq(25000);
        rc(8'h0c, 8'hc0, "flags");
        wirq(25000);
        chk(n_wait, 32'h00005f5c, "gap");
        rc(8'h0c, 8'hc0, "flags");
        wt(8'h0a, 8'h20);
        repeat (13000) @(posedge mclk);
        rc(8'h0c, 8'h00, "flags");
        $display("test periodic done");
        wt(8'h0b, 8'h80);
        pulse(3'h6);
        wt(8'h0b, 8'h81);
        pulse(3'h6);
        chk({n_fwd, n_back}, 8'h11, "shifts");
        @(posedge mclk);
        pwr_good <= 1'b0;
        repeat (6) @(posedge mclk);
        rc(8'h0d, 8'h00, "power");
        @(posedge mclk);
        pwr_good <= 1'b1;
        repeat (6) @(posedge mclk);
        rq(8'h0d);
        rc(8'h0d, 8'h80, "power");
        $display("test misc done");
        end_sim;
    end
endmodule
